// *** hw/lic_pkg.sv ***
/*
 Constants, field positions, reset values and the register request carrier
 for the line interface control register bank.
 Assumes a single 10 MHz system clock and a byte-wide register port.
*/
package lic_pkg;

    localparam int LIC_ADDR_W = 5;
    localparam int LIC_DATA_W = 8;

    typedef logic [LIC_ADDR_W-1:0] lic_addr_t;
    typedef logic [LIC_DATA_W-1:0] lic_byte_t;

    // One register access from the serial control frame decoder
    typedef struct packed {
        logic wr;
        logic rd;
        lic_addr_t addr;
        lic_byte_t wdata;
    } lic_req_s;

    // Register offsets
    localparam lic_addr_t LIC_OFS_CTRL1 = 5'h01;
    localparam lic_addr_t LIC_OFS_LINE1 = 5'h05;
    localparam lic_addr_t LIC_OFS_LINE2 = 5'h06;
    localparam lic_addr_t LIC_OFS_PLL1DIV = 5'h07;
    localparam lic_addr_t LIC_OFS_PLL1MUL = 5'h08;
    localparam lic_addr_t LIC_OFS_PLL2 = 5'h09;
    localparam lic_addr_t LIC_OFS_PLLMODE = 5'h0A;
    localparam lic_addr_t LIC_OFS_REV = 5'h0B;

    // Field positions
    localparam int LIC_BIT_SWRST = 7;
    localparam int LIC_BIT_RNEG = 6;
    localparam int LIC_BIT_RPOS = 5;
    localparam int LIC_BIT_POL = 4;
    localparam int LIC_BIT_ONHOOK_MONITOR_ENABLE = 3;
    localparam int LIC_BIT_RING = 2;
    localparam int LIC_BIT_OHE = 1;
    localparam int LIC_BIT_OH = 0;
    localparam int LIC_BIT_CPE = 7;
    localparam int LIC_BIT_ATM1 = 6;
    localparam int LIC_BIT_ARM1 = 5;
    localparam int LIC_BIT_PDL = 4;
    localparam int LIC_BIT_PDN = 3;
    localparam int LIC_BIT_ATM0 = 1;
    localparam int LIC_BIT_ARM0 = 0;
    localparam int LIC_BIT_CGM = 0;
    localparam int LIC_PLL2_DIV_LSB = 4;
    localparam int LIC_NIB_W = 4;

    // Writable bit masks
    localparam lic_byte_t LIC_LINE1_WMASK = 8'h1B;
    localparam lic_byte_t LIC_LINE2_WMASK = 8'hF3;
    localparam lic_byte_t LIC_MODE_WMASK = 8'h01;
    localparam lic_byte_t LIC_ZERO = 8'h00;

    // Reset values
    localparam lic_byte_t LIC_LINE1_RST = 8'h00;
    localparam lic_byte_t LIC_LINE2_RST = 8'h70;
    localparam lic_byte_t LIC_PLL1DIV_RST = 8'h00;
    localparam lic_byte_t LIC_PLL1MUL_RST = 8'h00;
    localparam lic_byte_t LIC_PLL2_RST = 8'h00;
    localparam lic_byte_t LIC_MODE_RST = 8'h00;

    // Timing
    localparam longint LIC_CLK_HZ = 10_000_000;
    localparam longint LIC_TICK_US = 1000;
    localparam int LIC_TICK_CYC =
        int'((LIC_CLK_HZ * LIC_TICK_US + 64'd999_999) / 64'd1_000_000);
    localparam longint LIC_RING_HOLD_MS = 4500;
    // One extra tick covers the unknown phase of the first tick
    localparam int LIC_HOLD_TICKS =
        int'((LIC_RING_HOLD_MS * 1000 + LIC_TICK_US - 1) / LIC_TICK_US) + 1;
    localparam int LIC_TICK_CNT_W = 14;
    localparam int LIC_HOLD_CNT_W = 13;

endpackage

// *** hw/lic_tick_div.sv ***
/*
 Divider giving a one-cycle enable pulse every CYCLES system clocks.
 Assumes CYCLES fits the counter width of the package.
*/
`timescale 1ns/1ps
module lic_tick_div #(
    parameter int CYCLES = lic_pkg::LIC_TICK_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clr,
    output logic tick
);
    import lic_pkg::*;

    logic [LIC_TICK_CNT_W-1:0] cnt_q;
    logic [LIC_TICK_CNT_W-1:0] cnt_d;
    logic wrap;

    assign wrap = (cnt_q == LIC_TICK_CNT_W'(CYCLES - 1));
    assign cnt_d = (clr || wrap) ? '0 : cnt_q + 1'b1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick <= wrap && !clr;
        end
    end

endmodule // lic_tick_div

// *** hw/lic_ring_flag.sv ***
/*
 Sticky ring indication with a hold timer counted in divider ticks.
 Assumes ring inputs are levels synchronous to clk.
*/
`timescale 1ns/1ps
module lic_ring_flag #(
    parameter int HOLD_TICKS = lic_pkg::LIC_HOLD_TICKS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic soft_clr,
    input wire logic tick,
    input wire logic ring_pos,
    input wire logic ring_neg,
    input wire logic offhook_rise,
    output logic ring_flag
);
    import lic_pkg::*;

    localparam logic [LIC_HOLD_CNT_W-1:0] HOLD_END =
        LIC_HOLD_CNT_W'(HOLD_TICKS);

    logic [LIC_HOLD_CNT_W-1:0] cnt_q;
    logic [LIC_HOLD_CNT_W-1:0] cnt_d;
    logic ring_any;
    logic expired;
    logic flag_d;

    assign ring_any = ring_pos || ring_neg;
    assign expired = (cnt_q == HOLD_END);
    // Saturates so the idle counter never wraps into a false ring
    assign cnt_d = (ring_any || soft_clr) ? '0 :
                   (tick && !expired) ? cnt_q + 1'b1 : cnt_q;
    // A ring in the clearing cycle wins over the clear
    assign flag_d = ring_any ? 1'b1 :
                    (offhook_rise || expired || soft_clr) ? 1'b0 : ring_flag;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= HOLD_END;
            ring_flag <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            ring_flag <= flag_d;
        end
    end

endmodule // lic_ring_flag

// *** hw/lic_regs.sv ***
/*
 Line interface control registers 5 to 11 with hook, ring, power-down,
 call-progress monitor and PLL setting outputs.
 Assumes a frame decoder that presents one access per REG_REQ strobe and
 inputs that are synchronous to CLK_SYS.
*/
// Overview of operation
// - Bit 6 of line control one reads the negative ring input live.
// - Bit 5 of line control one reads the positive ring input live.
// - Hook pin polarity bit 4: 0 active low, 1 active high.
// - Bit 3 enables on-hook line monitoring, driven out as a level.
// - Ring flag bit 2 sets on ring, clears after hold or off-hook.
// - Hook pin is ignored unless hook pin enable bit 1 is set.
// - Off-hook is request bit 0 OR enabled, polarity-corrected pin.
// - Bit 7 of line control two drives the charge pump enable.
// - Transmit monitor level is bits 6 and 1 of line control two.
// - Receive monitor level is bits 5 and 0 of line control two.
// - Bit 4 holds the line side in low power; host sets clocks first.
// - Bit 3 powers down the system side until an external reset.
// - Two 8-bit PLL1 divider and multiplier fields, value minus one.
// - PLL2 divider in bits 7:4, multiplier in bits 3:0.
// - Clock ratio bit selects no ratio or the 25/16 ratio.
// - Revision register returns a 4-bit revision, upper bits zero.
// - Self-clearing software reset bit 7 of control one resets registers.
`timescale 1ns/1ps
module lic_regs #(
    parameter int TICK_CYCLES = lic_pkg::LIC_TICK_CYC,
    parameter int HOLD_TICKS = lic_pkg::LIC_HOLD_TICKS,
    // Arbitrary value
    parameter logic [3:0] SYS_REVISION = 4'h0
) (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire lic_pkg::lic_req_s REG_REQ,
    output lic_pkg::lic_byte_t REG_RDATA,
    output logic REG_RVALID,
    input wire logic RING_POS,
    input wire logic RING_NEG,
    input wire logic HOOK_PIN,
    output logic OFFHOOK,
    output logic ONHOOK_MONITOR,
    output logic RING_DETECT,
    output logic PUMP_EN,
    output logic [1:0] MON_TX_LEVEL,
    output logic [1:0] MON_RX_LEVEL,
    output logic LINE_PWRDN,
    output logic SYS_PWRDN,
    output lic_pkg::lic_byte_t PLL1_DIV,
    output lic_pkg::lic_byte_t PLL1_MUL,
    output logic [3:0] PLL2_DIV,
    output logic [3:0] PLL2_MUL,
    output logic CLK_RATIO_SEL
);
    import lic_pkg::*;

    lic_byte_t line1_q, line1_d;
    lic_byte_t line2_q, line2_d;
    lic_byte_t pll1div_q, pll1div_d;
    lic_byte_t pll1mul_q, pll1mul_d;
    lic_byte_t pll2_q, pll2_d;
    lic_byte_t mode_q, mode_d;
    lic_byte_t line1_rd, line2_rd, rev_rd, rd_mux;
    logic sw_rst_q;
    logic sys_pwrdn_q;
    logic offhook_q, offhook_d;
    logic pin_asserted;
    logic ring_flag;
    logic tick;

    // Address decode
    wire wr_ctrl1 = REG_REQ.wr && (REG_REQ.addr == LIC_OFS_CTRL1);
    wire wr_line1 = REG_REQ.wr && (REG_REQ.addr == LIC_OFS_LINE1);
    wire wr_line2 = REG_REQ.wr && (REG_REQ.addr == LIC_OFS_LINE2);
    wire wr_pll1div = REG_REQ.wr && (REG_REQ.addr == LIC_OFS_PLL1DIV);
    wire wr_pll1mul = REG_REQ.wr && (REG_REQ.addr == LIC_OFS_PLL1MUL);
    wire wr_pll2 = REG_REQ.wr && (REG_REQ.addr == LIC_OFS_PLL2);
    wire wr_mode = REG_REQ.wr && (REG_REQ.addr == LIC_OFS_PLLMODE);
    wire sw_rst_req = wr_ctrl1 && REG_REQ.wdata[LIC_BIT_SWRST];

    // Only writable bits are stored
    assign line1_d = sw_rst_q ? LIC_LINE1_RST :
                     wr_line1 ? (REG_REQ.wdata & LIC_LINE1_WMASK) : line1_q;
    // Power-down bit lives apart so soft reset cannot revive the chip
    assign line2_d = sw_rst_q ? LIC_LINE2_RST :
                     wr_line2 ? (REG_REQ.wdata & LIC_LINE2_WMASK) : line2_q;
    assign pll1div_d = sw_rst_q ? LIC_PLL1DIV_RST :
                       wr_pll1div ? REG_REQ.wdata : pll1div_q;
    assign pll1mul_d = sw_rst_q ? LIC_PLL1MUL_RST :
                       wr_pll1mul ? REG_REQ.wdata : pll1mul_q;
    assign pll2_d = sw_rst_q ? LIC_PLL2_RST :
                    wr_pll2 ? REG_REQ.wdata : pll2_q;
    assign mode_d = sw_rst_q ? LIC_MODE_RST :
                    wr_mode ? (REG_REQ.wdata & LIC_MODE_WMASK) : mode_q;

    // Pin matches polarity bit when asserted
    assign pin_asserted = (HOOK_PIN == line1_q[LIC_BIT_POL]);
    // Request bit works with the pin disabled
    assign offhook_d = line1_q[LIC_BIT_OH] ||
                       (line1_q[LIC_BIT_OHE] && pin_asserted);

    always_comb begin
        line1_rd = line1_q;
        line1_rd[LIC_BIT_RNEG] = RING_NEG;
        line1_rd[LIC_BIT_RPOS] = RING_POS;
        line1_rd[LIC_BIT_RING] = ring_flag;
        line2_rd = line2_q;
        line2_rd[LIC_BIT_PDN] = sys_pwrdn_q;
        rev_rd = LIC_ZERO;
        rev_rd[LIC_NIB_W-1:0] = SYS_REVISION;
    end

    // Unmapped offsets and control one read zero; soft reset self-clears
    assign rd_mux = (REG_REQ.addr == LIC_OFS_LINE1) ? line1_rd :
                    (REG_REQ.addr == LIC_OFS_LINE2) ? line2_rd :
                    (REG_REQ.addr == LIC_OFS_PLL1DIV) ? pll1div_q :
                    (REG_REQ.addr == LIC_OFS_PLL1MUL) ? pll1mul_q :
                    (REG_REQ.addr == LIC_OFS_PLL2) ? pll2_q :
                    (REG_REQ.addr == LIC_OFS_PLLMODE) ? mode_q :
                    (REG_REQ.addr == LIC_OFS_REV) ? rev_rd : LIC_ZERO;

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            line1_q <= LIC_LINE1_RST;
            line2_q <= LIC_LINE2_RST;
            pll1div_q <= LIC_PLL1DIV_RST;
            pll1mul_q <= LIC_PLL1MUL_RST;
            pll2_q <= LIC_PLL2_RST;
            mode_q <= LIC_MODE_RST;
        end else begin
            line1_q <= line1_d;
            line2_q <= line2_d;
            pll1div_q <= pll1div_d;
            pll1mul_q <= pll1mul_d;
            pll2_q <= pll2_d;
            mode_q <= mode_d;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            sw_rst_q <= 1'b0;
            sys_pwrdn_q <= 1'b0;
            offhook_q <= 1'b0;
        end else begin
            sw_rst_q <= sw_rst_req;
            // Only the external reset clears this
            sys_pwrdn_q <= sys_pwrdn_q ||
                           (wr_line2 && REG_REQ.wdata[LIC_BIT_PDN]);
            offhook_q <= offhook_d;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            REG_RDATA <= LIC_ZERO;
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= REG_REQ.rd;
            if (REG_REQ.rd) begin
                REG_RDATA <= rd_mux;
            end
        end
    end

    lic_tick_div #(
        .CYCLES(TICK_CYCLES)
    ) lic_tick_div_inst (
        .clk(CLK_SYS),
        .rst_n(RSTN),
        .clr(sw_rst_q),
        .tick(tick)
    );

    lic_ring_flag #(
        .HOLD_TICKS(HOLD_TICKS)
    ) lic_ring_flag_inst (
        .clk(CLK_SYS),
        .rst_n(RSTN),
        .soft_clr(sw_rst_q),
        .tick(tick),
        .ring_pos(RING_POS),
        .ring_neg(RING_NEG),
        .offhook_rise(offhook_d && !offhook_q),
        .ring_flag(ring_flag)
    );

    assign OFFHOOK = offhook_q;
    assign ONHOOK_MONITOR = line1_q[LIC_BIT_ONHOOK_MONITOR_ENABLE];
    assign RING_DETECT = ring_flag;
    assign PUMP_EN = line2_q[LIC_BIT_CPE];
    assign MON_TX_LEVEL = {line2_q[LIC_BIT_ATM1],
                           line2_q[LIC_BIT_ATM0]};
    assign MON_RX_LEVEL = {line2_q[LIC_BIT_ARM1],
                           line2_q[LIC_BIT_ARM0]};
    assign LINE_PWRDN = line2_q[LIC_BIT_PDL];
    assign SYS_PWRDN = sys_pwrdn_q;
    assign PLL1_DIV = pll1div_q;
    assign PLL1_MUL = pll1mul_q;
    assign PLL2_DIV = pll2_q[LIC_PLL2_DIV_LSB +: LIC_NIB_W];
    assign PLL2_MUL = pll2_q[LIC_NIB_W-1:0];
    assign CLK_RATIO_SEL = mode_q[LIC_BIT_CGM];

    property p_ring_read;
        @(posedge CLK_SYS) disable iff (!RSTN)
        REG_REQ.rd && (REG_REQ.addr == LIC_OFS_LINE1) |=>
            REG_RVALID && (REG_RDATA[LIC_BIT_RNEG] == $past(RING_NEG)) &&
            (REG_RDATA[LIC_BIT_RPOS] == $past(RING_POS));
    endproperty
    a_ring_read: assert property (p_ring_read)
        else $error("ring status read mismatch");

    property p_pin_ignored;
        @(posedge CLK_SYS) disable iff (!RSTN)
        !line1_q[LIC_BIT_OHE] && !line1_q[LIC_BIT_OH] |=> !OFFHOOK;
    endproperty
    a_pin_ignored: assert property (p_pin_ignored)
        else $error("off-hook without request or enabled pin");

    property p_pin_polarity;
        @(posedge CLK_SYS) disable iff (!RSTN)
        line1_q[LIC_BIT_OHE] && (HOOK_PIN == line1_q[LIC_BIT_POL]) |=> OFFHOOK;
    endproperty
    a_pin_polarity: assert property (p_pin_polarity)
        else $error("asserted hook pin did not go off-hook");

    property p_request;
        @(posedge CLK_SYS) disable iff (!RSTN)
        line1_q[LIC_BIT_OH] |=> OFFHOOK;
    endproperty
    a_request: assert property (p_request)
        else $error("off-hook request ignored");

    property p_ring_set;
        @(posedge CLK_SYS) disable iff (!RSTN)
        RING_POS || RING_NEG |=> RING_DETECT;
    endproperty
    a_ring_set: assert property (p_ring_set)
        else $error("ring flag not set by ring");

    property p_ring_offhook;
        @(posedge CLK_SYS) disable iff (!RSTN)
        offhook_d && !offhook_q && !RING_POS && !RING_NEG |=> !RING_DETECT;
    endproperty
    a_ring_offhook: assert property (p_ring_offhook)
        else $error("ring flag not cleared at off-hook");

    property p_pdn_sticky;
        @(posedge CLK_SYS) disable iff (!RSTN)
        SYS_PWRDN |=> SYS_PWRDN;
    endproperty
    a_pdn_sticky: assert property (p_pdn_sticky)
        else $error("system power-down released without reset");

    property p_soft_reset;
        @(posedge CLK_SYS) disable iff (!RSTN)
        sw_rst_req |=> ##1 (line2_q == LIC_LINE2_RST) &&
            (pll1div_q == LIC_PLL1DIV_RST) && !CLK_RATIO_SEL;
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("software reset did not restore registers");

    property p_readonly;
        @(posedge CLK_SYS) disable iff (!RSTN)
        wr_line1 && !sw_rst_q |=>
            (line1_q & ~LIC_LINE1_WMASK) == LIC_ZERO;
    endproperty
    a_readonly: assert property (p_readonly)
        else $error("read-only bits were stored");

    property p_pll_write;
        @(posedge CLK_SYS) disable iff (!RSTN)
        wr_pll2 && !sw_rst_q |=>
            ({PLL2_DIV, PLL2_MUL} == $past(REG_REQ.wdata));
    endproperty
    a_pll_write: assert property (p_pll_write)
        else $error("PLL2 fields not updated by write");

    property p_pll1_write;
        @(posedge CLK_SYS) disable iff (!RSTN)
        wr_pll1div && !sw_rst_q |=> (PLL1_DIV == $past(REG_REQ.wdata));
    endproperty
    a_pll1_write: assert property (p_pll1_write)
        else $error("PLL1 divider not updated by write");

    property p_line2_write;
        @(posedge CLK_SYS) disable iff (!RSTN)
        wr_line2 && !sw_rst_q |=>
            (PUMP_EN == $past(REG_REQ.wdata[LIC_BIT_CPE])) &&
            (LINE_PWRDN == $past(REG_REQ.wdata[LIC_BIT_PDL]));
    endproperty
    a_line2_write: assert property (p_line2_write)
        else $error("pump or line power-down not updated by write");

    property p_mon_write;
        @(posedge CLK_SYS) disable iff (!RSTN)
        wr_line2 && !sw_rst_q |=> ({MON_TX_LEVEL, MON_RX_LEVEL} ==
            $past({REG_REQ.wdata[LIC_BIT_ATM1], REG_REQ.wdata[LIC_BIT_ATM0],
                REG_REQ.wdata[LIC_BIT_ARM1], REG_REQ.wdata[LIC_BIT_ARM0]}));
    endproperty
    a_mon_write: assert property (p_mon_write)
        else $error("monitor levels not updated by write");

    property p_ratio_write;
        @(posedge CLK_SYS) disable iff (!RSTN)
        wr_mode && !sw_rst_q |=>
            (CLK_RATIO_SEL == $past(REG_REQ.wdata[LIC_BIT_CGM]));
    endproperty
    a_ratio_write: assert property (p_ratio_write)
        else $error("clock ratio select not updated by write");

    property p_rev_read;
        @(posedge CLK_SYS) disable iff (!RSTN)
        REG_REQ.rd && (REG_REQ.addr == LIC_OFS_REV) |=>
            REG_RVALID && (REG_RDATA[LIC_NIB_W-1:0] == SYS_REVISION) &&
            ((REG_RDATA >> LIC_NIB_W) == LIC_ZERO);
    endproperty
    a_rev_read: assert property (p_rev_read)
        else $error("revision read mismatch");

endmodule // lic_regs

// *** tb/lic_host_model.sv ***
/*
 Host model: drives the register strobe port and the device reset pin.
 Assumes callers enter its tasks just after a rising clock edge.
*/
`timescale 1ns/1ps
module lic_host_model (
    input wire logic clk,
    input wire lic_pkg::lic_byte_t rdata,
    input wire logic rvalid,
    output lic_pkg::lic_req_s req,
    output logic rstn
);
    import lic_pkg::*;
    initial begin
        req = '0;
        rstn = 1'b0;
    end
    // Only this pin restores a powered-down system side
    task automatic pulse_reset();
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        #1;
    endtask
    // Strobe stands for one taking edge; a quiet cycle follows
    task automatic wr(input lic_addr_t a, input lic_byte_t d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
        #1;
    endtask
    task automatic rd(input lic_addr_t a, output lic_byte_t d,
                      output logic v);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: LIC_ZERO};
        @(posedge clk);
        req <= '0;
        #1;
        v = rvalid;
        d = rdata;
    endtask
    // Clocks first: waking the line side unclocked would misbehave
    task automatic wake(input lic_byte_t n1, input lic_byte_t m1,
                        input lic_byte_t p2, input lic_byte_t md);
        wr(LIC_OFS_PLL1DIV, n1);
        wr(LIC_OFS_PLL1MUL, m1);
        wr(LIC_OFS_PLL2, p2);
        wr(LIC_OFS_PLLMODE, md);
        wr(LIC_OFS_LINE2, 8'h00);
    endtask
endmodule // lic_host_model

// *** tb/tb_top.sv ***
/*
 Self-checking bench for the line interface control registers.
 Assumes small tick and hold counts so ring timing fits a short run.
*/
`timescale 1ns/1ps
module tb_top;
    import lic_pkg::*;
    localparam int LIMIT = 4000;
    // Arbitrary revision value
    localparam logic [3:0] REV = 4'hA;
    logic clk_sys = 1'b0;
    logic rstn, rvalid, ring_pos = 1'b0, ring_neg = 1'b0, hook_pin = 1'b0;
    logic offhook, onhook_mon, ring_det, pump_en, line_pd, sys_pd, ratio;
    logic [1:0] tx_lvl, rx_lvl;
    logic [3:0] pll2_div, pll2_mul;
    lic_req_s req;
    lic_byte_t rdata, pll1_div, pll1_mul;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;
    always #50 clk_sys = ~clk_sys;
    lic_host_model lic_host_model_inst (.clk(clk_sys), .rdata(rdata),
        .rvalid(rvalid), .req(req), .rstn(rstn));
    lic_regs #(.TICK_CYCLES(10), .HOLD_TICKS(5), .SYS_REVISION(REV))
    lic_regs_inst (.CLK_SYS(clk_sys), .RSTN(rstn), .REG_REQ(req),
        .REG_RDATA(rdata), .REG_RVALID(rvalid), .RING_POS(ring_pos),
        .RING_NEG(ring_neg), .HOOK_PIN(hook_pin), .OFFHOOK(offhook),
        .ONHOOK_MONITOR(onhook_mon), .RING_DETECT(ring_det),
        .PUMP_EN(pump_en), .MON_TX_LEVEL(tx_lvl), .MON_RX_LEVEL(rx_lvl),
        .LINE_PWRDN(line_pd), .SYS_PWRDN(sys_pd), .PLL1_DIV(pll1_div),
        .PLL1_MUL(pll1_mul), .PLL2_DIV(pll2_div), .PLL2_MUL(pll2_mul),
        .CLK_RATIO_SEL(ratio));
    wire lic_byte_t ports = {pump_en, line_pd, sys_pd, offhook, tx_lvl,
                             rx_lvl};
    task automatic stop_test();
        if (failures == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input lic_byte_t e,
                       input lic_byte_t g);
        n_tests++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask
    task automatic rdchk(input lic_addr_t a, input lic_byte_t e);
        lic_byte_t d;
        logic v;
        lic_host_model_inst.rd(a, d, v);
        chk($sformatf("rvalid %h", a), 8'h01, {7'h00, v});
        chk($sformatf("reg %h", a), e, d);
    endtask
    // Generous ceiling; the sequence needs well under half of it
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            failures++;
            stop_test();
        end
    end
    localparam lic_addr_t RA [9] = '{5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
                                     5'h0A, 5'h0B, 5'h01, 5'h1F};
    localparam lic_byte_t RV [9] = '{8'h00, 8'h70, 8'h00, 8'h00, 8'h00,
                                     8'h00, {4'h0, REV}, 8'h00, 8'h00};
    initial begin
        lic_byte_t d, x;
        lic_host_model_inst.pulse_reset();
        chk("ports", 8'h4A, ports);
        for (int i = 0; i < 9; i++) begin
            rdchk(RA[i], RV[i]);
        end
        lic_host_model_inst.wake(8'hC7, 8'h5A, 8'hC3, 8'hFF);
        lic_host_model_inst.wr(LIC_OFS_REV, 8'hFF);
        chk("pll1_div", 8'hC7, pll1_div);
        chk("pll1_mul", 8'h5A, pll1_mul);
        chk("pll2", 8'hC3, {pll2_div, pll2_mul});
        chk("ratio", 8'h01, {7'h00, ratio});
        chk("line_pwrdn", 8'h00, {7'h00, line_pd});
        rdchk(LIC_OFS_PLLMODE, 8'h01);
        rdchk(LIC_OFS_REV, {4'h0, REV});
        lic_host_model_inst.wr(LIC_OFS_PLLMODE, 8'hFE);
        chk("ratio", 8'h00, {7'h00, ratio});
        for (int i = 0; i < 16; i++) begin
            x = 8'(i);
            d = {x[0] ^ x[3], x[3], x[1], 3'b001, x[2], x[0]};
            lic_host_model_inst.wr(LIC_OFS_LINE2, d);
            chk("mon_tx", {6'h00, x[3:2]}, {6'h00, tx_lvl});
            chk("mon_rx", {6'h00, x[1:0]}, {6'h00, rx_lvl});
            chk("pump_en", {7'h00, d[7]}, {7'h00, pump_en});
            rdchk(LIC_OFS_LINE2, d & 8'hFB);
        end
        for (int i = 0; i < 32; i++) begin
            x = 8'(i);
            @(posedge clk_sys) hook_pin <= x[3];
            d = {3'b111, x[0], x[4], 1'b1, x[1], x[2]};
            lic_host_model_inst.wr(LIC_OFS_LINE1, d);
            @(posedge clk_sys);
            #1;
            chk("offhook", {7'h00, x[2] | (x[1] & (x[3] == x[0]))},
                {7'h00, offhook});
            chk("onhook_mon", {7'h00, x[4]}, {7'h00, onhook_mon});
            rdchk(LIC_OFS_LINE1, d & 8'h1B);
        end
        lic_host_model_inst.wr(LIC_OFS_LINE1, 8'h00);
        @(posedge clk_sys) ring_pos <= 1'b1;
        rdchk(LIC_OFS_LINE1, 8'h24);
        @(posedge clk_sys) ring_pos <= 1'b0;
        ring_neg <= 1'b1;
        rdchk(LIC_OFS_LINE1, 8'h44);
        @(posedge clk_sys) ring_neg <= 1'b0;
        repeat (35) @(posedge clk_sys);
        #1;
        chk("ring_hold", 8'h01, {7'h00, ring_det});
        repeat (25) @(posedge clk_sys);
        #1;
        chk("ring_clear", 8'h00, {7'h00, ring_det});
        @(posedge clk_sys) ring_pos <= 1'b1;
        @(posedge clk_sys) ring_pos <= 1'b0;
        lic_host_model_inst.wr(LIC_OFS_LINE1, 8'h01);
        chk("ring_set", 8'h01, {7'h00, ring_det});
        @(posedge clk_sys);
        #1;
        chk("hook_clear", 8'h02, {6'h00, offhook, ring_det});
        lic_host_model_inst.wr(LIC_OFS_LINE2, 8'h08);
        chk("sys_pwrdn", 8'h01, {7'h00, sys_pd});
        lic_host_model_inst.wr(LIC_OFS_CTRL1, 8'h80);
        repeat (3) @(posedge clk_sys);
        #1;
        chk("ports", 8'h6A, ports);
        rdchk(LIC_OFS_LINE2, 8'h78);
        rdchk(LIC_OFS_PLL1DIV, 8'h00);
        rdchk(LIC_OFS_CTRL1, 8'h00);
        lic_host_model_inst.pulse_reset();
        chk("ports", 8'h4A, ports);
        stop_test();
    end
endmodule // tb_top
